/* logic/timer_event_counter.sv */
// 16-bit timer/event counter with mode control, compare and capture.
// Assumes APB master, pins synchronous to pclk.
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_event_counter (
  input  wire logic               pclk,              // APB clock
  input  wire logic               presetn,           // Async reset
  input  wire logic               psel,              // APB select
  input  wire logic               penable,           // APB enable
  input  wire logic               pwrite,            // APB write
  input  wire logic [`ADDR_W-1:0] paddr,             // APB address
  input  wire logic [31:0]        pwdata,            // APB wdata
  output logic      [31:0]        prdata,            // APB rdata
  output logic                    pready,            // APB ready
  output logic                    pslverr,           // APB error
  input  wire logic               first_input_pin,   // Input 0
  input  wire logic               second_input_pin,  // Input 1
  output logic                    toggle_output_pin, // Timer out
  output logic                    first_match_irq,   // Match 0
  output logic                    second_match_irq   // Match 1
);
  import timer_pkg::*;

  // ================================================
  // State
  timer_pkg::run_ctrl_t run_control_reg, run_control_next;
  timer_pkg::cap_ctrl_t capture_control_reg, capture_control_next;
  timer_pkg::edge_sel_t prescale_edge_reg, prescale_edge_next;
  logic [15:0] first_capcomp_reg, first_capcomp_next;
  logic [15:0] second_capcomp_reg, second_capcomp_next;
  logic [15:0] count_value_reg, count_value_next;
  logic        zero_arm_reg, zero_arm_next;
  logic        pin0_reg, pin0_next;
  logic        pin1_reg, pin1_next;
  logic        tout_reg, tout_next;
  logic        irq0_reg, irq0_next;
  logic        irq1_reg, irq1_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        err_reg, err_next;

  // ================================================
  // Decode and pin events
  logic        running;
  logic        rise0, fall0, rise1, fall1;
  logic        valid0, valid1, rev0;
  logic        hit_run, hit_c0, hit_c1, hit_cc, hit_es, hit_cnt;
  logic        mapped, wr_en;
  logic [15:0] idx;
  logic [31:0] rmux;

  // Address match against word indices
  always_comb begin
    idx     = paddr[`ADDR_W-1:2];
    hit_run = (idx == `RUN_IDX);
    hit_c0  = (idx == `CMP0_IDX);
    hit_c1  = (idx == `CMP1_IDX);
    hit_cc  = (idx == `CAPCTL_IDX);
    hit_es  = (idx == `EDGE_IDX);
    hit_cnt = (idx == `COUNT_IDX);
    mapped  = (paddr[1:0] == 2'h0) &
              (hit_run | hit_c0 | hit_c1 | hit_cc | hit_es | hit_cnt);
    wr_en   = psel & penable & pwrite & mapped;
  end

  // Read mux; upper mode bits read zero
  always_comb begin
    rmux = 32'h0000_0000;
    if (hit_run) begin
      rmux[3:0] = run_control_reg;
    end else if (hit_c0) begin
      rmux[15:0] = first_capcomp_reg;
    end else if (hit_c1) begin
      rmux[15:0] = second_capcomp_reg;
    end else if (hit_cc) begin
      rmux[2:0] = capture_control_reg;
    end else if (hit_es) begin
      rmux[7:4] = prescale_edge_reg;
    end else if (hit_cnt) begin
      rmux[15:0] = count_value_reg;
    end
  end

  // Edge detection on both input pins
  always_comb begin
    running = (run_control_reg.run_field != `RUN_STOP);
    rise0   = first_input_pin & ~pin0_reg;
    fall0   = ~first_input_pin & pin0_reg;
    rise1   = second_input_pin & ~pin1_reg;
    fall1   = ~second_input_pin & pin1_reg;
    unique case (prescale_edge_reg.first_edge)
      `EDGE_FALL: valid0 = fall0;
      `EDGE_RISE: valid0 = rise0;
      `EDGE_BOTH: valid0 = rise0 | fall0;
      default:    valid0 = 1'b0;
    endcase
    // Reverse phase of the first pin
    unique case (prescale_edge_reg.first_edge)
      `EDGE_FALL: rev0 = rise0;
      `EDGE_RISE: rev0 = fall0;
      default:    rev0 = 1'b0;
    endcase
    unique case (prescale_edge_reg.second_edge)
      `EDGE_FALL: valid1 = fall1;
      `EDGE_RISE: valid1 = rise1;
      `EDGE_BOTH: valid1 = rise1 | fall1;
      default:    valid1 = 1'b0;
    endcase
  end

  // ================================================
  // Counter, compare, capture and output logic
  logic m0, m1, cap0, cap1, clr_edge, clr_match, wrap, rev_mode;

  always_comb begin
    rev_mode = capture_control_reg.first_capture &
               capture_control_reg.capture_source_select;
    // Compare: zero value waits for step after a clear or wrap
    if (first_capcomp_reg == `CNT_ZERO) begin
      m0 = zero_arm_reg & (count_value_reg == `CNT_ZERO);
    end else begin
      m0 = (count_value_reg == first_capcomp_reg);
    end
    if (second_capcomp_reg == `CNT_ZERO) begin
      m1 = zero_arm_reg & (count_value_reg == `CNT_ZERO);
    end else begin
      m1 = (count_value_reg == second_capcomp_reg);
    end
    m0 = m0 & running & ~capture_control_reg.first_capture;
    m1 = m1 & running & ~capture_control_reg.second_capture;
    // Capture triggers
    cap0 = running & capture_control_reg.first_capture &
           (capture_control_reg.capture_source_select ? rev0 : valid1);
    cap1 = running & capture_control_reg.second_capture &
           valid0;
    // Clear conditions per run mode
    clr_edge  = running &
                (run_control_reg.run_field == `RUN_EDGE) & valid0;
    clr_match = (run_control_reg.run_field == `RUN_MATCH) & m0;
    wrap      = running & (count_value_reg == `CNT_MAX) &
                ~clr_edge & ~clr_match;
  end

  // Next values of counter, pins, output and interrupts
  always_comb begin
    pin0_next = first_input_pin;
    pin1_next = second_input_pin;
    if (!running) begin
      count_value_next = `CNT_ZERO;
    end else if (clr_edge | clr_match) begin
      count_value_next = `CNT_ZERO;
    end else begin
      count_value_next = count_value_reg + `CNT_ONE;
    end
    // Arm zero match only after a clear or wrap, not after start
    zero_arm_next = running & (clr_edge | clr_match | wrap);
    tout_next = tout_reg;
    if (m0 | m1) begin
      tout_next = ~tout_reg;
    end else if (running & run_control_reg.toggle_select_bit &
                 valid0) begin
      tout_next = ~tout_reg;
    end
    // Reverse-phase capture gives no irq; second pin does
    irq0_next = m0 | (cap0 & ~rev_mode) |
                (running & rev_mode & valid1);
    irq1_next = m1 | cap1;
  end

  // Registers: APB writes, captures and wrap flag
  always_comb begin
    run_control_next     = run_control_reg;
    capture_control_next = capture_control_reg;
    prescale_edge_next   = prescale_edge_reg;
    first_capcomp_next   = first_capcomp_reg;
    second_capcomp_next  = second_capcomp_reg;
    if (wr_en & hit_run) begin
      run_control_next = pwdata[3:0];
    end
    if (wr_en & hit_cc) begin
      capture_control_next = pwdata[2:0];
    end
    if (wr_en & hit_es) begin
      prescale_edge_next = pwdata[7:4];
    end
    // Capture wins over a software write
    if (cap0) begin
      first_capcomp_next = count_value_reg;
    end else if (wr_en & hit_c0) begin
      first_capcomp_next = pwdata[15:0];
    end
    if (cap1) begin
      second_capcomp_next = count_value_reg;
    end else if (wr_en & hit_c1) begin
      second_capcomp_next = pwdata[15:0];
    end
    // Stop clears; wrap wins over a cleared write
    if (run_control_next.run_field == `RUN_STOP) begin
      run_control_next.wrap_flag = 1'b0;
    end else if (wrap) begin
      run_control_next.wrap_flag = 1'b1;
    end
  end

  // APB answer: data captured in setup, zero wait
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (psel & ~penable) begin
      rdata_next = pwrite ? 32'h0000_0000 : rmux;
      err_next   = ~mapped;
    end
    pready  = psel & penable;
    pslverr = psel & penable & err_reg;
    prdata  = rdata_reg;
  end

  assign toggle_output_pin = tout_reg;
  assign first_match_irq   = irq0_reg;
  assign second_match_irq  = irq1_reg;

  // ================================================
  // Flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_control_reg     <= `RUN_RST;
      capture_control_reg <= `CAPCTL_RST;
      prescale_edge_reg   <= `EDGE_RST;
      first_capcomp_reg   <= `CNT_ZERO;
      second_capcomp_reg  <= `CNT_ZERO;
      count_value_reg     <= `CNT_ZERO;
      zero_arm_reg        <= 1'b0;
      pin0_reg            <= 1'b0;
      pin1_reg            <= 1'b0;
      tout_reg            <= 1'b0;
      irq0_reg            <= 1'b0;
      irq1_reg            <= 1'b0;
      rdata_reg           <= 32'h0000_0000;
      err_reg             <= 1'b0;
    end else begin
      run_control_reg     <= run_control_next;
      capture_control_reg <= capture_control_next;
      prescale_edge_reg   <= prescale_edge_next;
      first_capcomp_reg   <= first_capcomp_next;
      second_capcomp_reg  <= second_capcomp_next;
      count_value_reg     <= count_value_next;
      zero_arm_reg        <= zero_arm_next;
      pin0_reg            <= pin0_next;
      pin1_reg            <= pin1_next;
      tout_reg            <= tout_next;
      irq0_reg            <= irq0_next;
      irq1_reg            <= irq1_next;
      rdata_reg           <= rdata_next;
      err_reg             <= err_next;
    end
  end
endmodule : timer_event_counter

/* logic/timer_params.svh */
// Constants for the 16-bit timer/event counter with mode control.
// Assumes APB byte addresses of four times each register index.
// Operation
// - Zero compare: no match at start
// - Zero compare matches on step after clear
// - Second capture ignores source select bit
// - Reverse-phase capture raises no first match
// - Then second pin edge raises first match
// - Reset clears mode control register
// - Nonzero run field starts counting
// - Run field 00 stops and clears
// - 01 free, 10 edge clear, 11 match clear
// - Toggle select 0: invert on matches
// - Toggle select 1: also on input edge
// - Set wrap flag on FFFF to 0000
// - Wrap flag cleared by 0, set by 1
// - Compare continuously; value held until rewrite
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
// ==================================================
// Register indices and address layout
`define ADDR_W       18
`define RUN_IDX      16'hFFBA
`define CMP0_IDX     16'hFFB0
`define CMP1_IDX     16'hFFB1
`define CAPCTL_IDX   16'hFFB2
`define EDGE_IDX     16'hFFB3
`define COUNT_IDX    16'hFFB4
// ==================================================
// Field values and reset values
`define RUN_STOP     2'h0
`define RUN_FREE     2'h1
`define RUN_EDGE     2'h2
`define RUN_MATCH    2'h3
`define CNT_ZERO     16'h0000
`define CNT_MAX      16'hFFFF
`define CNT_ONE      16'h0001
`define EDGE_FALL    2'h0
`define EDGE_RISE    2'h1
`define EDGE_BOTH    2'h3
`define RUN_RST      4'h0
`define CAPCTL_RST   3'h0
`define EDGE_RST     4'h0
`endif

/* logic/timer_pkg.sv */
// Types shared by the timer/event counter.
// Assumes timer_params.svh is compiled alongside.
package timer_pkg;
  // ================================================
  // Mode control register fields
  typedef struct packed {
    logic [1:0] run_field;         // run_field_high, run_field_low
    logic       toggle_select_bit; // Toggle on input edge too
    logic       wrap_flag;         // Counter wrapped
  } run_ctrl_t;
  // ================================================
  // Capture control fields
  typedef struct packed {
    logic second_capture;          // Second register captures
    logic capture_source_select;   // First: reverse phase source
    logic first_capture;           // First register captures
  } cap_ctrl_t;
  // ================================================
  // Edge select fields
  typedef struct packed {
    logic [1:0] second_edge;       // Second pin valid edge
    logic [1:0] first_edge;        // First pin valid edge
  } edge_sel_t;
endpackage : timer_pkg

/* verif/pin_model.sv */
// Far-side model: drives the two timer input pins.
// Assumes pins are sampled on the rising edge of pclk.
`timescale 1ns/1ps
module pin_model (
  input  wire logic pclk,            // Clock
  output logic      first_input_pin, // Input 0
  output logic      second_input_pin // Input 1
);
  // Pins idle low
  initial begin
    first_input_pin = 1'b0;
    second_input_pin = 1'b0;
  end
  // One-cycle high pulse, changed just after an edge
  task automatic pulse(input bit sel);
    @(posedge pclk);
    if (sel) second_input_pin <= 1'b1;
    else first_input_pin <= 1'b1;
    @(posedge pclk);
    first_input_pin <= 1'b0;
    second_input_pin <= 1'b0;
  endtask : pulse
endmodule : pin_model

/* verif/timer_event_counter_asserts.sv */
// Checker for the timer/event counter, bound to its ports.
// Assumes zero-wait APB and byte address of four times the index.
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_event_counter_asserts (
  input wire logic               pclk,              // Clock
  input wire logic               presetn,           // Reset
  input wire logic               psel,              // Select
  input wire logic               penable,           // Enable
  input wire logic               pwrite,            // Write
  input wire logic [`ADDR_W-1:0] paddr,             // Address
  input wire logic [31:0]        pwdata,            // Write data
  input wire logic [31:0]        prdata,            // Read data
  input wire logic               pready,            // Ready
  input wire logic               pslverr,           // Error
  input wire logic               first_input_pin,   // Input 0
  input wire logic               second_input_pin,  // Input 1
  input wire logic               toggle_output_pin, // Output
  input wire logic               first_match_irq,   // Match 0
  input wire logic               second_match_irq   // Match 1
);
  logic [2:0] sh_reg, sh_next;   // Run field and toggle select
  logic [1:0] stp_reg, stp_next; // Edges spent stopped
  logic       acc, run_rd, stopped;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access decode
  assign acc = psel && penable;
  assign run_rd = acc && !pwrite && paddr == {`RUN_IDX, 2'b00};
  assign stopped = sh_reg[2:1] == `RUN_STOP && stp_reg[1];
  // Shadow of the mode fields
  always_comb begin
    sh_next = sh_reg;
    stp_next = stp_reg;
    if (acc && pwrite && paddr == {`RUN_IDX, 2'b00}) sh_next = pwdata[3:1];
    if (sh_reg[2:1] != `RUN_STOP) stp_next = 2'h0;
    else if (stp_reg != 2'h3) stp_next = stp_reg + 2'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_reg <= 3'h0;
      stp_reg <= 2'h0;
    end else begin
      sh_reg <= sh_next;
      stp_reg <= stp_next;
    end
  end
  a_ready_nowait: assert property (acc |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (acc && (paddr[1:0] != 2'h0 ||
    !(paddr[17:2] inside {[`CMP0_IDX:`COUNT_IDX], `RUN_IDX})) |-> pslverr)
    else $error("no error on unmapped access");
  a_upper_zero: assert property (run_rd |-> prdata[31:4] == 28'h0)
    else $error("upper mode bits not zero");
  a_run_readback: assert property (run_rd |-> prdata[3:1] == sh_reg)
    else $error("run field readback wrong");
  a_flag_stopped: assert property (run_rd && stopped |-> !prdata[0])
    else $error("wrap flag set while stopped");
  a_count_cleared: assert property (acc && !pwrite && stopped &&
    paddr == {`COUNT_IDX, 2'b00} |-> prdata[15:0] == `CNT_ZERO)
    else $error("count not cleared when stopped");
  a_stop_silent: assert property (stopped |-> !first_match_irq &&
    !second_match_irq && $stable(toggle_output_pin))
    else $error("activity while stopped");
  a_toggle_cause: assert property ($changed(toggle_output_pin) &&
    !sh_reg[0] |-> first_match_irq || second_match_irq)
    else $error("output toggled without a match");
endmodule : timer_event_counter_asserts
bind timer_event_counter timer_event_counter_asserts u_asserts (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .first_input_pin, .second_input_pin, .toggle_output_pin,
  .first_match_irq, .second_match_irq);

/* verif/timer_event_counter_tb.sv */
// Directed testbench for the timer/event counter over APB.
// Assumes the design, the checker and the pin model are compiled.
`timescale 1ns/1ps
`include "timer_params.svh"
`define CHK(g, e) chk_val(32'(g), 32'(e))
module timer_event_counter_tb;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, rd_q;
  logic               first_input_pin, second_input_pin, toggle_output_pin;
  logic               first_match_irq, second_match_irq, err_q, t0;
  int                 errors, num_checks, cycles, n;
  timer_event_counter u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .first_input_pin,
    .second_input_pin, .toggle_output_pin, .first_match_irq,
    .second_match_irq);
  pin_model u_pins (.pclk, .first_input_pin, .second_input_pin);
  // Clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors = errors + 1;
      stop_test();
    end
  end
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_val
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Cycles until a match pulse, sampled after each edge settles
  task automatic wait_irq(input bit sel, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while ((sel ? second_match_irq : first_match_irq) !== 1'b1 &&
               n < lim);
  endtask : wait_irq
  // ================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = '0;
    pwdata = 32'h0;
    {errors, num_checks, cycles} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `RUN_IDX, 0);
    `CHK(rd_q, 32'h0);
    apb(0, 16'h0100, 0);
    `CHK(err_q, 1'b1);
    apb(1, `CMP0_IDX, 3);
    apb(1, `CMP1_IDX, 5);
    apb(1, `RUN_IDX, 32'h4);
    wait_irq(0, 20);
    `CHK(n, 4);
    `CHK(toggle_output_pin, 1'b1);
    wait_irq(1, 20);
    `CHK(n, 2);
    `CHK(toggle_output_pin, 1'b0);
    apb(1, `RUN_IDX, 0);
    apb(0, `COUNT_IDX, 0);
    `CHK(rd_q, 32'h0);
    // Clear on first compare match
    apb(1, `CMP0_IDX, 2);
    apb(1, `RUN_IDX, 32'hC);
    for (int i = 0; i < 3; i++) begin
      wait_irq(0, 20);
      `CHK(n, 3);
    end
    apb(1, `RUN_IDX, 0);
    // Clear on input edge, output toggled by the edge too
    apb(1, `EDGE_IDX, 32'h10);
    apb(1, `CMP0_IDX, 16'h100);
    apb(1, `RUN_IDX, 32'hA);
    repeat (20) @(posedge pclk);
    #1;
    t0 = toggle_output_pin;
    u_pins.pulse(0);
    repeat (3) @(posedge pclk);
    #1;
    `CHK(toggle_output_pin, !t0);
    apb(0, `COUNT_IDX, 0);
    `CHK(rd_q < 32'h8, 1'b1);
    // Zero compare in free run, then wrap flag handling
    apb(1, `RUN_IDX, 0);
    apb(1, `CMP0_IDX, 0);
    apb(1, `RUN_IDX, 32'h4);
    wait_irq(0, 8);
    `CHK(first_match_irq, 1'b0);
    wait_irq(0, 70000);
    `CHK(first_match_irq, 1'b1);
    apb(0, `RUN_IDX, 0);
    `CHK(rd_q, 32'h5);
    apb(1, `RUN_IDX, 32'h4);
    apb(0, `RUN_IDX, 0);
    `CHK(rd_q, 32'h4);
    apb(1, `RUN_IDX, 32'h5);
    apb(0, `RUN_IDX, 0);
    `CHK(rd_q, 32'h5);
    apb(1, `RUN_IDX, 32'hF1);
    apb(0, `RUN_IDX, 0);
    `CHK(rd_q, 32'h0);
    // Reverse-phase capture into the first register
    apb(1, `CMP0_IDX, 16'h1234);
    apb(1, `EDGE_IDX, 32'h40);
    apb(1, `CAPCTL_IDX, 32'h3);
    apb(1, `RUN_IDX, 32'h4);
    // Watch from the pulse edge on; the match pulse is one cycle long
    fork
      u_pins.pulse(1);
      wait_irq(0, 4);
    join
    `CHK(first_match_irq, 1'b1);
    apb(0, `CMP0_IDX, 0);
    `CHK(rd_q, 32'h1234);
    fork
      u_pins.pulse(0);
      wait_irq(0, 6);
    join
    `CHK(first_match_irq, 1'b0);
    apb(0, `CMP0_IDX, 0);
    `CHK(rd_q != 32'h1234, 1'b1);
    stop_test();
  end
endmodule : timer_event_counter_tb
